// [pkg/scanner_regs.svh]
// Register map, field positions, reset values and timing for the scanner.
`ifndef SCANNER_REGS_SVH
`define SCANNER_REGS_SVH
// What this block does
// - Partial warning sensitivity OFF, Low, Medium, High; OFF default disables it.
// - Partial detection delay settable 1 to 60 s, default 5 s.
// - Partial judging distance settable 35 to 100 mm, default 60 mm.
// - Start angle -5 to 185 degrees, default -5; above end angle is refused.
// - End angle -5 to 185 degrees, default 185; below start angle is refused.
// - Whole-window warning: sensitivity choice, OFF default, delay 1 to 60 s.
// - Each region output high while clear, low while object in its region.
// - Malfunction output high normally, low on internal active-part fault.
// - Contamination output low normally, high on enabled contamination detection.
// - Synchronous output gives a 1 ms pulse at each scan start.
// - A normal scan lasts 20 ms, so the pulse repeats every 20 ms.
// - During malfunction the synchronous output stays on.
// - Master reference clock keeps running even during malfunction.
// - Every unit locks its scan to the master reference on its sync input.

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CTRL_OFS      8'h00
`define PDELAY_OFS    8'h04
`define WDELAY_OFS    8'h08
`define PRANGE_OFS    8'h0C
`define ANGLE_OFS     8'h10
`define STATUS_OFS    8'h14
`define IRQ_STAT_OFS  8'h18
`define IRQ_CLR_OFS   8'h1C
`define IRQ_EN_OFS    8'h20

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CTRL_WSENS_LSB  2
`define ANG_END_LSB     16
`define DELAY_MIN_S     6'h01
`define DELAY_MAX_S     6'h3C
`define DELAY_RST_S     6'h05
`define RANGE_MIN_MM    7'h23
`define RANGE_MAX_MM    7'h64
`define RANGE_RST_MM    7'h3C
`define ANG_MIN_DEG     9'h1FB
`define ANG_MAX_DEG     9'h0B9
`define THR_LOW         8'hC0
`define THR_MEDIUM      8'h80
`define THR_HIGH        8'h40
`define IRQ_CONTAM      0
`define IRQ_FAULT       1
`define IRQ_REJECT      2
`define IRQ_OBJECT      3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define MS_NS           1000000
`define MS_PER_S        16'h03E8
`define SCAN_MS         5'h14
`define SYNC_PULSE_MS   5'h01
`define REF_HIGH_MS     5'h0A
`endif

// [pkg/scanner_pkg.sv]
// Types shared by the scanner output logic.
package scanner_pkg;
    typedef enum logic [1:0] {
        SENS_OFF    = 2'b00,
        SENS_LOW    = 2'b01,
        SENS_MEDIUM = 2'b10,
        SENS_HIGH   = 2'b11
    } sens_type;

    typedef struct packed {
        logic [15:0] ms;
        logic        conf;
    } timer_state_type;

    typedef struct packed {
        sens_type           psens;
        sens_type           wsens;
        logic [5:0]         pdelay;
        logic [5:0]         wdelay;
        logic [6:0]         prange;
        logic signed [8:0]  ang_start;
        logic signed [8:0]  ang_end;
        logic [3:0]         irq_stat;
        logic [3:0]         irq_en;
        logic               wr_pend;
        logic [7:0]         wr_addr;
        logic [31:0]        rdata;
        logic [2:0]         det;
        logic               malf;
        logic               contam;
        logic               sync;
        logic               smaster;
        logic [31:0]        ref_pre;
        logic [31:0]        scan_pre;
        logic [4:0]         ref_ms;
        logic [4:0]         scan_ms;
        logic [1:0]         sync_ff;
        logic               sync_prev;
        logic               pacc;
        logic               pdirty;
        logic               wdirty;
    } main_state_type;
endpackage

// [pkg/contam_if.sv]
// Link between the output logic and one contamination delay timer.
`timescale 1ns/100ps
interface contam_if;
    logic       en;
    logic       dirty;
    logic       tick;
    logic [5:0] delay_s;
    logic       confirmed;

    modport owner (output en, output dirty, output tick, output delay_s,
                   input confirmed);
    modport timer (input en, input dirty, input tick, input delay_s,
                   output confirmed);
endinterface

// [design/contam_timer.sv]
// Delay timer that confirms a contamination indication after its delay.
`timescale 1ns/100ps
`include "scanner_regs.svh"
module contam_timer (
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    contam_if.timer   c
);
    scanner_pkg::timer_state_type r;
    scanner_pkg::timer_state_type n;
    logic [15:0]                  delay_ms;

    always_comb begin
        n = r;
        delay_ms = 16'(c.delay_s) * `MS_PER_S;
        if (!c.en || !c.dirty) begin
            n.ms = 16'h0000;
            n.conf = 1'b0;
        end else if (c.tick && !r.conf) begin
            if (r.ms + 16'h0001 >= delay_ms) begin
                n.conf = 1'b1;
            end else begin
                n.ms = r.ms + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign c.confirmed = r.conf;

    timer_restart_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !c.dirty |=> !r.conf && r.ms == 16'h0000)
        else $error("Timer did not restart when dirt cleared.");
    timer_cause_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $rose(r.conf) |-> $past(c.en && c.dirty && c.tick))
        else $error("Timer confirmed without a dirty tick.");
endmodule

// [design/scanner_output_signalling.sv]
// Output signalling of the area scanner with its AHB-Lite register slave.
`timescale 1ns/100ps
`include "scanner_regs.svh"
module scanner_output_signalling #(
    parameter int unsigned MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
    input  wire logic               ref_clk_i,
    input  wire logic               reset_i,
    input  wire logic               hsel_i,
    input  wire logic [31:0]        haddr_i,
    input  wire logic [1:0]         htrans_i,
    input  wire logic               hwrite_i,
    input  wire logic [2:0]         hsize_i,
    input  wire logic [31:0]        hwdata_i,
    input  wire logic               hready_i,
    output logic      [31:0]        hrdata_o,
    output logic                    hreadyout_o,
    output logic                    hresp_o,
    input  wire logic [2:0]         region_hit_i,
    input  wire logic               fault_i,
    input  wire logic               echo_valid_i,
    input  wire logic signed [8:0]  echo_angle_i,
    input  wire logic [15:0]        echo_dist_i,
    input  wire logic [7:0]         echo_level_i,
    input  wire logic [7:0]         whole_level_i,
    input  wire logic               sync_in_i,
    output logic      [2:0]         det_o,
    output logic                    malfunction_o,
    output logic                    contam_o,
    output logic                    sync_o,
    output logic                    sync_master_o,
    output logic                    irq_o
);

    // ------------------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------------------
    scanner_pkg::main_state_type r;
    scanner_pkg::main_state_type n;

    contam_if pif ();
    contam_if wif ();

    logic        tick_ref;
    logic        tick_scan;
    logic        scan_end;
    logic        sync_rise;
    logic        pcur;
    logic        ang_ok;
    logic        ang_bad;
    logic [3:0]  ev;
    logic [3:0]  clr;
    logic [31:0] rd;

    // Lower sensitivity needs a stronger dirt level before it counts.
    function automatic logic [7:0] thr(input scanner_pkg::sens_type s);
        unique case (s)
            scanner_pkg::SENS_LOW:    thr = `THR_LOW;
            scanner_pkg::SENS_MEDIUM: thr = `THR_MEDIUM;
            scanner_pkg::SENS_HIGH:   thr = `THR_HIGH;
            scanner_pkg::SENS_OFF:    thr = 8'hFF;
        endcase
    endfunction

    function automatic logic in_ang(input logic signed [8:0] a);
        in_ang = a >= $signed(`ANG_MIN_DEG) && a <= $signed(`ANG_MAX_DEG);
    endfunction

    function automatic logic in_delay(input logic [31:0] d);
        in_delay = d[5:0] >= `DELAY_MIN_S && d[5:0] <= `DELAY_MAX_S
                   && d[31:6] == 26'h0;
    endfunction

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        n = r;

        // The first stage only feeds the second one.
        n.sync_ff = {r.sync_ff[0], sync_in_i};
        n.sync_prev = r.sync_ff[1];
        sync_rise = r.sync_ff[1] && !r.sync_prev;

        tick_ref = r.ref_pre == MS_CYCLES - 1;
        n.ref_pre = tick_ref ? 32'h0 : r.ref_pre + 32'h1;
        if (tick_ref) begin
            n.ref_ms = (r.ref_ms == `SCAN_MS - 5'h01) ? 5'h00
                                                      : r.ref_ms + 5'h01;
        end
        n.smaster = n.ref_ms < `REF_HIGH_MS;

        // scan locks to the master edge
        tick_scan = r.scan_pre == MS_CYCLES - 1;
        scan_end = tick_scan && r.scan_ms == `SCAN_MS - 5'h01;
        if (sync_rise) begin
            n.scan_pre = 32'h0;
            n.scan_ms = 5'h00;
        end else begin
            n.scan_pre = tick_scan ? 32'h0 : r.scan_pre + 32'h1;
            if (tick_scan) begin
                n.scan_ms = scan_end ? 5'h00 : r.scan_ms + 5'h01;
            end
        end

        // pulse at scan start, held on during a fault
        n.sync = fault_i || n.scan_ms < `SYNC_PULSE_MS;

        n.det = ~region_hit_i;
        n.malf = !fault_i;

        // partial window judgment by distance and angle
        pcur = r.psens != scanner_pkg::SENS_OFF && echo_valid_i
               && echo_dist_i <= 16'(r.prange)
               && echo_angle_i >= r.ang_start && echo_angle_i <= r.ang_end
               && echo_level_i >= thr(r.psens);
        // Dirt is judged per scan so single echoes do not flicker the timer.
        if (scan_end || sync_rise) begin
            n.pdirty = r.pacc || pcur;
            n.pacc = 1'b0;
        end else begin
            n.pacc = r.pacc || pcur;
        end
        n.wdirty = r.wsens != scanner_pkg::SENS_OFF
                   && whole_level_i >= thr(r.wsens);

        // either delayed judgment, raises the output
        n.contam = pif.confirmed || wif.confirmed;

        // Register read data is captured in the address phase.
        unique case (haddr_i[7:0])
            `CTRL_OFS:     rd = {28'h0, r.wsens, r.psens};
            `PDELAY_OFS:   rd = {26'h0, r.pdelay};
            `WDELAY_OFS:   rd = {26'h0, r.wdelay};
            `PRANGE_OFS:   rd = {25'h0, r.prange};
            `ANGLE_OFS:    rd = {7'h0, r.ang_end, 7'h0, r.ang_start};
            `STATUS_OFS:   rd = {24'h0, r.pdirty, r.wdirty, r.contam,
                                 r.malf, r.sync, r.det};
            `IRQ_STAT_OFS: rd = {28'h0, r.irq_stat};
            `IRQ_EN_OFS:   rd = {28'h0, r.irq_en};
            default:       rd = 32'h0;
        endcase
        if (hsel_i && htrans_i[1] && hready_i) begin
            n.wr_pend = hwrite_i;
            n.wr_addr = haddr_i[7:0];
            if (!hwrite_i) begin
                n.rdata = rd;
            end
        end else begin
            n.wr_pend = 1'b0;
        end

        // angle pair checked as one write
        ang_ok = in_ang(hwdata_i[8:0])
                 && in_ang(hwdata_i[`ANG_END_LSB +: 9])
                 && $signed(hwdata_i[8:0])
                    <= $signed(hwdata_i[`ANG_END_LSB +: 9]);
        ang_bad = 1'b0;
        clr = 4'h0;
        if (r.wr_pend) begin
            unique case (r.wr_addr)
                `CTRL_OFS: begin
                    n.psens = scanner_pkg::sens_type'(hwdata_i[1:0]);
                    n.wsens = scanner_pkg::sens_type'(
                        hwdata_i[`CTRL_WSENS_LSB +: 2]);
                end
                `PDELAY_OFS: begin
                    if (in_delay(hwdata_i)) begin
                        n.pdelay = hwdata_i[5:0];
                    end
                end
                `WDELAY_OFS: begin
                    if (in_delay(hwdata_i)) begin
                        n.wdelay = hwdata_i[5:0];
                    end
                end
                `PRANGE_OFS: begin
                    if (hwdata_i[6:0] >= `RANGE_MIN_MM
                        && hwdata_i[6:0] <= `RANGE_MAX_MM
                        && hwdata_i[31:7] == 25'h0) begin
                        n.prange = hwdata_i[6:0];
                    end
                end
                `ANGLE_OFS: begin
                    if (ang_ok) begin
                        n.ang_start = hwdata_i[8:0];
                        n.ang_end = hwdata_i[`ANG_END_LSB +: 9];
                    end else begin
                        ang_bad = 1'b1;
                    end
                end
                `IRQ_CLR_OFS: clr = hwdata_i[3:0];
                `IRQ_EN_OFS:  n.irq_en = hwdata_i[3:0];
                default: ;
            endcase
        end

        // A new event beats a clear in the same cycle.
        ev = 4'h0;
        ev[`IRQ_CONTAM] = n.contam && !r.contam;
        ev[`IRQ_FAULT] = fault_i && r.malf;
        ev[`IRQ_REJECT] = ang_bad;
        ev[`IRQ_OBJECT] = |(region_hit_i & r.det);
        n.irq_stat = (r.irq_stat & ~clr) | ev;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '0;
            r.pdelay <= `DELAY_RST_S;
            r.wdelay <= `DELAY_RST_S;
            r.prange <= `RANGE_RST_MM;
            r.ang_start <= `ANG_MIN_DEG;
            r.ang_end <= `ANG_MAX_DEG;
            r.det <= 3'h7;
            r.malf <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------------
    // Delay timers
    // ------------------------------------------------------------------------
    assign pif.en = r.psens != scanner_pkg::SENS_OFF;
    assign pif.dirty = r.pdirty;
    assign pif.tick = tick_ref;
    assign pif.delay_s = r.pdelay;
    assign wif.en = r.wsens != scanner_pkg::SENS_OFF;
    assign wif.dirty = r.wdirty;
    assign wif.tick = tick_ref;
    assign wif.delay_s = r.wdelay;

    contam_timer ptimer (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .c         (pif.timer)
    );

    contam_timer wtimer (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .c         (wif.timer)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign hrdata_o = r.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign det_o = r.det;
    assign malfunction_o = r.malf;
    assign contam_o = r.contam;
    assign sync_o = r.sync;
    assign sync_master_o = r.smaster;
    assign irq_o = |(r.irq_stat & r.irq_en);

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    logic [31:0] hi_cnt;
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hi_cnt <= 32'h0;
        end else begin
            // A re-phase starts a new scan, so its pulse is counted afresh.
            hi_cnt <= (sync_o && !fault_i && !sync_rise) ? hi_cnt + 32'h1
                                                         : 32'h0;
        end
    end

    sequence ang_write_bad;
        r.wr_pend && r.wr_addr == `ANGLE_OFS && !ang_ok;
    endsequence

    sequence sens_all_off;
        r.psens == scanner_pkg::SENS_OFF && r.wsens == scanner_pkg::SENS_OFF;
    endsequence

    det_follow_a: assert property (
        region_hit_i[0] |=> !det_o[0])
        else $error("Region output stayed high during detection.");
    malf_low_a: assert property (
        fault_i |=> !malfunction_o)
        else $error("Malfunction output not low on fault.");
    contam_cause_a: assert property (
        $rose(contam_o) |-> $past(pif.confirmed || wif.confirmed))
        else $error("Contamination output rose without a judgment.");
    sens_off_a: assert property (
        sens_all_off [*3] |-> !contam_o)
        else $error("Contamination output high with both functions off.");
    sync_fault_a: assert property (
        fault_i |=> sync_o)
        else $error("Synchronous output not held on during fault.");
    sync_width_a: assert property (
        hi_cnt <= MS_CYCLES + 1)
        else $error("Synchronous pulse longer than one millisecond.");
    scan_len_a: assert property (
        r.scan_ms < `SCAN_MS && r.ref_ms < `SCAN_MS)
        else $error("Scan counter passed twenty milliseconds.");
    ref_runs_a: assert property (
        fault_i |=> r.ref_pre != $past(r.ref_pre))
        else $error("Reference clock stalled during fault.");
    ang_keep_a: assert property (
        ang_write_bad |=> $stable(r.ang_start) && $stable(r.ang_end)
                          && r.irq_stat[`IRQ_REJECT])
        else $error("Bad angle write was not refused.");
    delay_range_a: assert property (
        r.pdelay >= `DELAY_MIN_S && r.pdelay <= `DELAY_MAX_S)
        else $error("Partial delay left its range.");
endmodule

// [tb/sync_partner.sv]
// Far-side model that loops the master reference back to the sync input.
`timescale 1ns/100ps
module sync_partner #(
    parameter int LAG = 1
) (
    input  wire logic clk_i,
    input  wire logic ref_i,
    output logic      sync_in_o
);
    logic [7:0] dly_r;

    // Cleared at start so the input pin never floats to an unknown level.
    initial dly_r = 8'h00;

    always @(posedge clk_i) dly_r <= {dly_r[6:0], ref_i};
    assign sync_in_o = dly_r[LAG-1];
endmodule

// [tb/scanner_output_signalling_test.sv]
// Self-checking bench of the scanner output signalling block.
`timescale 1ns/100ps
`include "scanner_regs.svh"
module scanner_output_signalling_test;
    localparam int MS = 20;
    localparam logic [7:0]  CA [8] = '{`PDELAY_OFS, `PDELAY_OFS, `PDELAY_OFS,
        `WDELAY_OFS, `PRANGE_OFS, `PRANGE_OFS, `ANGLE_OFS, `ANGLE_OFS};
    localparam logic [31:0] CD [8] = '{32'h00, 32'h3D, 32'h3C, 32'h01,
        32'h22, 32'h64, 32'h0009000A, 32'h00BA01FB};
    localparam logic [31:0] CE [8] = '{32'h05, 32'h05, 32'h3C, 32'h01,
        32'h3C, 32'h64, 32'h00B901FB, 32'h00B901FB};
    logic        ref_clk_i;
    logic        reset_i;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hready;
    logic [2:0]  hit;
    logic        fault;
    logic [7:0]  wlevel;
    logic        evalid;
    logic signed [8:0] eang;
    logic [15:0] edist;
    logic [7:0]  elvl;
    logic        sync_in;
    logic [2:0]  det;
    logic        malf;
    logic        contam;
    logic        sync;
    logic        smaster;
    logic        irq;
    logic        last;
    logic [31:0] rd;
    logic [31:0] seed;
    int          fail_count;
    int          n_checks;
    int          k;
    int          n;
    int          t;

    scanner_output_signalling #(.MS_CYCLES(MS)) dut_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
        .region_hit_i(hit), .fault_i(fault), .echo_valid_i(evalid),
        .echo_angle_i(eang), .echo_dist_i(edist),
        .echo_level_i(elvl), .whole_level_i(wlevel), .sync_in_i(sync_in),
        .det_o(det), .malfunction_o(malf), .contam_o(contam),
        .sync_o(sync), .sync_master_o(smaster), .irq_o(irq));

    sync_partner #(.LAG(2)) far_u (
        .clk_i(ref_clk_i), .ref_i(smaster), .sync_in_o(sync_in));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits are never assumed: each phase ends only when hready is seen.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_i);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge ref_clk_i); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge ref_clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(rd, e);
    endtask

    task automatic cnt(input logic v, output int c);
        c = 0;
        while (sync !== v && c < 1000) begin
            @(negedge ref_clk_i);
            c++;
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        repeat (80000) @(posedge ref_clk_i);
        fail_count++;
        summarize();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        reset_i = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        hit = 3'h0;
        fault = 1'b0;
        wlevel = 8'h00;
        evalid = 1'b0;
        eang = 9'h000;
        edist = 16'h0000;
        elvl = 8'h00;
        fail_count = 0;
        n_checks = 0;
        seed = 32'h000019AA;
        repeat (5) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rdchk(`CTRL_OFS, 32'h00000000);
        rdchk(`PDELAY_OFS, 32'h00000005);
        rdchk(`WDELAY_OFS, 32'h00000005);
        rdchk(`PRANGE_OFS, 32'h0000003C);
        rdchk(`ANGLE_OFS, 32'h00B901FB);
        rdchk(8'h40, 32'h00000000);
        for (k = 0; k < 8; k++) begin
            bus(1'b1, CA[k], CD[k]);
            rdchk(CA[k], CE[k]);
        end
        rdchk(`IRQ_STAT_OFS, 32'h00000004);
        $display("test registers done");
        for (k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            hit <= seed[2:0];
            repeat (2) @(posedge ref_clk_i);
            chk({29'h0, det}, {29'h0, ~seed[2:0]});
        end
        hit <= 3'h0;
        fault <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk({31'h0, malf}, 32'h00000000);
        n = 0;
        t = 0;
        last = smaster;
        for (k = 0; k < 500; k++) begin
            @(negedge ref_clk_i);
            n += (sync !== 1'b1);
            t += (smaster !== last);
            last = smaster;
        end
        chk(n, 0);
        chk(t >= 2, 1);
        @(posedge ref_clk_i);
        fault <= 1'b0;
        $display("test outputs done");
        repeat (1000) @(posedge ref_clk_i);
        cnt(1'b0, n);
        cnt(1'b1, n);
        cnt(1'b0, n);
        chk(n, MS);
        cnt(1'b1, n);
        chk(n, 19 * MS);
        $display("test sync done");
        bus(1'b1, `IRQ_CLR_OFS, 32'h0000000F);
        rdchk(`IRQ_STAT_OFS, 32'h00000000);
        wlevel <= 8'hFF;
        repeat (21000) @(posedge ref_clk_i);
        chk({31'h0, contam}, 32'h00000000);
        wlevel <= 8'h00;
        bus(1'b1, `IRQ_EN_OFS, 32'h00000001);
        bus(1'b1, `CTRL_OFS, 32'h0000000C);
        wlevel <= 8'hFF;
        repeat (10000) @(posedge ref_clk_i);
        wlevel <= 8'h00;
        repeat (3) @(posedge ref_clk_i);
        wlevel <= 8'hFF;
        repeat (19900) @(posedge ref_clk_i);
        chk({31'h0, contam}, 32'h00000000);
        n = 0;
        while (contam !== 1'b1 && n < 300) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk(n < 300, 1);
        chk({31'h0, irq}, 32'h00000001);
        rdchk(`IRQ_STAT_OFS, 32'h00000001);
        bus(1'b1, `IRQ_EN_OFS, 32'h00000000);
        @(negedge ref_clk_i);
        chk({31'h0, irq}, 32'h00000000);
        bus(1'b1, `IRQ_EN_OFS, 32'h00000001);
        bus(1'b1, `IRQ_CLR_OFS, 32'h00000001);
        @(negedge ref_clk_i);
        chk({31'h0, irq}, 32'h00000000);
        $display("test contamination done");
        bus(1'b1, `CTRL_OFS, 32'h0000000F);
        evalid <= 1'b1;
        eang <= 9'h05A;
        edist <= 16'h00C8;
        elvl <= 8'hFF;
        repeat (900) @(posedge ref_clk_i);
        bus(1'b0, `STATUS_OFS, 32'h00000000);
        chk({31'h0, rd[7]}, 32'h00000000);
        edist <= 16'h0064;
        repeat (900) @(posedge ref_clk_i);
        bus(1'b0, `STATUS_OFS, 32'h00000000);
        chk({31'h0, rd[7]}, 32'h00000001);
        eang <= 9'h0BA;
        repeat (900) @(posedge ref_clk_i);
        bus(1'b0, `STATUS_OFS, 32'h00000000);
        chk({31'h0, rd[7]}, 32'h00000000);
        bus(1'b1, `CTRL_OFS, 32'h00000000);
        repeat (3) @(negedge ref_clk_i);
        chk({31'h0, contam}, 32'h00000000);
        $display("test partial done");
        summarize();
    end
endmodule
